// ===== hw/active_mode_pkg.sv
/*
 Package for the active stop mode controller: register offsets, field
 positions, reset values, setting ranges, timing constants and state codes.
 Assumes a 50 MHz system clock and a 125 us control cycle strobe.
*/
package active_mode_pkg;

   // Register word offsets on the plain register port
   localparam logic [3:0] REG_CTRL        = 4'h0;
   localparam logic [3:0] REG_DECEL_A     = 4'h1;
   localparam logic [3:0] REG_DECEL_B     = 4'h2;
   localparam logic [3:0] REG_STOP_LVL    = 4'h3;
   localparam logic [3:0] REG_HOLD_TIME   = 4'h4;
   localparam logic [3:0] REG_POS_ERR_LVL = 4'h5;
   localparam logic [3:0] REG_SPD_REF_LVL = 4'h6;
   localparam logic [3:0] REG_STATUS      = 4'h7;
   localparam logic [3:0] REG_POS_ERR     = 4'h8;
   localparam logic [3:0] REG_SPEED_CMD   = 4'h9;

   // Control register fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_STOP_LSB   = 1;
   localparam int CTRL_STOP_W     = 2;

   // Status register fields
   localparam int STAT_CHAN_A_LSB = 0;
   localparam int STAT_CHAN_B_LSB = 2;
   localparam int STAT_REQ_A_BIT  = 4;
   localparam int STAT_REQ_B_BIT  = 5;
   localparam int STAT_TORQ_BIT   = 8;
   localparam int STAT_ACTIVE_BIT = 16;

   // Reset values
   localparam logic [31:0] DECEL_RST       = 32'h0000_2710;
   localparam logic [31:0] STOP_LVL_RST    = 32'h0000_000A;
   localparam logic [31:0] HOLD_TIME_RST   = 32'h0000_0064;
   localparam logic [31:0] POS_ERR_LVL_RST = 32'h0000_0064;
   localparam logic [31:0] SPD_REF_LVL_RST = 32'h0000_000A;

   // Setting ranges
   localparam logic [31:0] DECEL_MIN       = 32'h0000_0001;
   localparam logic [31:0] DECEL_MAX       = 32'h0000_7530;
   localparam logic [31:0] LVL_MIN         = 32'h0000_0000;
   localparam logic [31:0] SPEED_LVL_MAX   = 32'h0000_2710;
   localparam logic [31:0] HOLD_TIME_MAX   = 32'h0000_2710;
   localparam logic [31:0] POS_ERR_LVL_MIN = 32'h0000_0001;
   localparam logic [31:0] POS_ERR_LVL_MAX = 32'h3FFF_FFFF;

   // Timing
   localparam int CLK_HZ         = 50_000_000;
   localparam int TIMEBASE_MS    = 10;
   localparam int TIMEBASE_CYC   = CLK_HZ / 1000 * TIMEBASE_MS;
   localparam int CTRL_PERIOD_US = 125;
   localparam int RAMP_FRAC      = 20;
   // Ramp step per tick = decel * period, in Q20, via a 2^30 scale
   localparam logic [63:0] RAMP_STEP_NUM =
      ((64'(CTRL_PERIOD_US) << 30) + 64'd999999) / 64'd1000000;

   // Control modes from the drive
   typedef enum logic [1:0] {
      MODE_POSITION = 2'b00,
      MODE_SPEED    = 2'b01,
      MODE_TORQUE   = 2'b10
   } ctrl_mode_t;

   // Per-channel active mode states, Gray along the usual path
   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_DECEL   = 2'b01,
      ST_HOLD    = 2'b11,
      ST_RELEASE = 2'b10
   } chan_state_t;

endpackage

// ===== hw/active_mode_channel.sv
/*
 One channel of the active stop mode: state machine, deceleration ramp,
 stop detection and hold timer with its own 10 ms timebase.
 Assumes all inputs are already in the system clock domain.
*/
`timescale 1ns/1ps
module active_mode_channel
   import active_mode_pkg::*;
#(
   parameter int P_TB_CYCLES = TIMEBASE_CYC
) (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   // Conditions
   input  wire logic        i_arm,
   input  wire logic        i_req,
   input  wire logic        i_kill,
   input  wire logic        i_servo_on,
   input  wire logic        i_release_ok,
   input  wire logic        i_ctrl_tick,
   // Settings and feedback
   input  wire logic [31:0] i_motor_abs,
   input  wire logic [31:0] i_stop_level,
   input  wire logic [31:0] i_decel,
   input  wire logic [31:0] i_hold_time,
   // Results
   output logic             o_active,
   output logic [31:0]      o_speed,
   output chan_state_t      o_state
);

   chan_state_t state_q;
   logic [51:0] ramp_q;
   logic [19:0] tb_cnt_q;
   logic [13:0] hold_cnt_q;
   logic        stopped;
   logic        hold_done;
   logic [63:0] step_wide;
   logic [51:0] step;

   assign stopped   = i_motor_abs <= i_stop_level;
   assign hold_done = {18'h0, hold_cnt_q} >= i_hold_time;
   assign step_wide = (64'(i_decel) * RAMP_STEP_NUM) >> 10;
   assign step      = step_wide[51:0];

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || i_kill) begin
         state_q <= ST_STANDBY;
      end else begin
         unique case (state_q)
            ST_STANDBY: if (i_arm && !i_req) state_q <= ST_DECEL;
            ST_DECEL:   if (stopped) state_q <= ST_HOLD;
            // Request input ignored until hold expires
            ST_HOLD:    if (hold_done) state_q <= ST_RELEASE;
            ST_RELEASE: begin
               if (i_req && !i_servo_on && i_release_ok) begin
                  state_q <= ST_STANDBY;
               end
            end
         endcase
      end
   end

   // Ramp from the speed at takeover, clamped at zero
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         ramp_q <= 52'h0;
      end else if (state_q == ST_STANDBY) begin
         ramp_q <= {i_motor_abs, 20'h0};
      end else if (state_q == ST_DECEL && i_ctrl_tick) begin
         ramp_q <= (ramp_q > step) ? ramp_q - step : 52'h0;
      end else if (state_q != ST_DECEL) begin
         ramp_q <= 52'h0;
      end
   end

   // Timebase held clear outside ST_HOLD; counting starts on entry to ST_HOLD, the cycle after the first stopped cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state_q != ST_HOLD) begin
         tb_cnt_q   <= 20'h0;
         hold_cnt_q <= 14'h0;
      end else if (tb_cnt_q == 20'(P_TB_CYCLES - 1)) begin
         tb_cnt_q   <= 20'h0;
         hold_cnt_q <= hold_done ? hold_cnt_q : hold_cnt_q + 14'h1;
      end else begin
         tb_cnt_q   <= tb_cnt_q + 20'h1;
      end
   end

   assign o_active = state_q != ST_STANDBY;
   assign o_speed  = ramp_q[RAMP_FRAC +: 32];
   assign o_state  = state_q;

endmodule

// ===== hw/active_mode_decel_controller.sv
/*
 Active stop mode controller: two channel state machines, speed override
 combining, position error tracking, release checks and register port.
 Assumes loop signals and the control tick come from the system clock
 domain; the safety request inputs are asynchronous pins.
*/
`timescale 1ns/1ps

// Summary of operation
// - Request input low with mode enabled: take over with internal ramp.
// - Separate deceleration constants A and B, 1..30000, default 10000.
// - Active stop works only in position or speed control.
// - Trigger in torque control turns servo off, stop per method select.
// - Release needs servo-on inactive and that request input active.
// - Active stop mode is enabled or disabled by a setting.
// - Show the active stop indication while active.
// - Channels A and B run independent state machines.
// - Both channels active: command the lower of the two ramp speeds.
// - Servo-ready loss or any alarm cancels active mode at once.
// - Motor stopped when speed falls to stop level, 0..10000, default 10.
// - Hold stopped motor for hold time, 0..10000 x 10 ms, default 100.
// - During hold, ignore request inputs; release only after expiry.
// - Position control: accumulate host reference minus motor position.
// - No release while position error exceeds level, default 100.
// - Speed control: stay active while host reference exceeds level.
// - Status bit 16 reads 1 while active, else 0.
module active_mode_decel_controller
   import active_mode_pkg::*;
#(
   parameter int P_TB_CYCLES = TIMEBASE_CYC
) (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   // Register port
   input  wire logic [3:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic [31:0]      o_reg_rdata,
   // Safety request pins
   input  wire logic        i_safety_req_a,
   input  wire logic        i_safety_req_b,
   // Drive state
   input  wire logic [1:0]  i_ctrl_mode,
   input  wire logic        i_servo_on,
   input  wire logic        i_servo_ready,
   input  wire logic        i_alarm,
   input  wire logic        i_ctrl_tick,
   // References and feedback, signed
   input  wire logic [31:0] i_host_speed_ref,
   input  wire logic [31:0] i_motor_speed,
   input  wire logic [31:0] i_pos_ref_delta,
   input  wire logic [31:0] i_pos_fb_delta,
   // Loop outputs
   output logic             o_decel_override,
   output logic [31:0]      o_decel_speed,
   output logic             o_decel_dir_neg,
   output logic             o_servo_off,
   output logic [1:0]       o_stop_method_select,
   output logic             o_active_stop_indication,
   output logic [39:0]      o_pos_error
);

   // Magnitude of a signed word; most negative value saturates
   function automatic logic [31:0] abs32(input logic [31:0] v);
      logic [31:0] r;
      r = v[31] ? (32'h0 - v) : v;
      if (r[31]) begin
         r = 32'h7FFF_FFFF;
      end
      return r;
   endfunction

   // Clamp a written setting into its legal range
   function automatic logic [31:0] clamp32(input logic [31:0] v,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
      logic [31:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   // Synchronisers for the safety request pins
   logic [1:0]  req_a_sync_q;
   logic [1:0]  req_b_sync_q;
   logic        req_a;
   logic        req_b;

   // Settings
   logic        enable_q;
   logic [1:0]  stop_method_q;
   logic [31:0] decel_a_q;
   logic [31:0] decel_b_q;
   logic [31:0] stop_lvl_q;
   logic [31:0] hold_time_q;
   logic [31:0] pos_err_lvl_q;
   logic [31:0] spd_ref_lvl_q;

   // State
   logic [39:0] pos_err_q;
   logic [39:0] pos_err_abs;
   logic [31:0] speed_cmd_q;
   logic        override_q;
   logic        dir_neg_q;
   logic        servo_off_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [31:0] status;

   // Decode
   ctrl_mode_t  mode;
   logic        mode_ok;
   logic        torque_mode;
   logic        kill;
   logic        release_ok;
   logic [31:0] motor_abs;
   logic [31:0] host_ref_abs;
   logic        any_active;

   // Per-channel vectors
   logic [1:0]       chan_req;
   logic [1:0]       chan_active;
   logic [31:0]      chan_speed [2];
   logic [31:0]      chan_decel [2];
   chan_state_t      chan_state [2];

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         req_a_sync_q <= 2'b00;
         req_b_sync_q <= 2'b00;
      end else begin
         req_a_sync_q <= {req_a_sync_q[0], i_safety_req_a};
         req_b_sync_q <= {req_b_sync_q[0], i_safety_req_b};
      end
   end

   assign req_a = req_a_sync_q[1];
   assign req_b = req_b_sync_q[1];

   assign mode         = ctrl_mode_t'(i_ctrl_mode);
   assign mode_ok      = mode == MODE_POSITION || mode == MODE_SPEED;
   assign torque_mode  = mode == MODE_TORQUE;
   assign kill         = !i_servo_ready || i_alarm;
   assign motor_abs    = abs32(i_motor_speed);
   assign host_ref_abs = abs32(i_host_speed_ref);
   assign pos_err_abs  = pos_err_q[39] ? (40'h0 - pos_err_q) : pos_err_q;
   assign any_active   = |chan_active;

   // Release check depends on the loop's current control mode
   always_comb begin
      release_ok = 1'b1;
      if (mode == MODE_POSITION) begin
         release_ok = pos_err_abs <= {8'h0, pos_err_lvl_q};
      end else if (mode == MODE_SPEED) begin
         release_ok = host_ref_abs <= spd_ref_lvl_q;
      end
   end

   // Register writes; out-of-range values are clamped, effective at once
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         enable_q      <= 1'b0;
         stop_method_q <= 2'b00;
         decel_a_q     <= DECEL_RST;
         decel_b_q     <= DECEL_RST;
         stop_lvl_q    <= STOP_LVL_RST;
         hold_time_q   <= HOLD_TIME_RST;
         pos_err_lvl_q <= POS_ERR_LVL_RST;
         spd_ref_lvl_q <= SPD_REF_LVL_RST;
      end else if (i_reg_wr) begin
         unique case (i_reg_addr)
            REG_CTRL: begin
               enable_q      <= i_reg_wdata[CTRL_ENABLE_BIT];
               stop_method_q <= i_reg_wdata[CTRL_STOP_LSB +: CTRL_STOP_W];
            end
            REG_DECEL_A: begin
               decel_a_q <= clamp32(i_reg_wdata, DECEL_MIN, DECEL_MAX);
            end
            REG_DECEL_B: begin
               decel_b_q <= clamp32(i_reg_wdata, DECEL_MIN, DECEL_MAX);
            end
            REG_STOP_LVL: begin
               stop_lvl_q <= clamp32(i_reg_wdata, LVL_MIN, SPEED_LVL_MAX);
            end
            REG_HOLD_TIME: begin
               hold_time_q <= clamp32(i_reg_wdata, LVL_MIN, HOLD_TIME_MAX);
            end
            REG_POS_ERR_LVL: begin
               pos_err_lvl_q <= clamp32(i_reg_wdata, POS_ERR_LVL_MIN,
                                        POS_ERR_LVL_MAX);
            end
            REG_SPD_REF_LVL: begin
               spd_ref_lvl_q <= clamp32(i_reg_wdata, LVL_MIN, SPEED_LVL_MAX);
            end
            default: begin
            end
         endcase
      end
   end

   assign chan_req      = {req_b, req_a};
   assign chan_decel[0] = decel_a_q;
   assign chan_decel[1] = decel_b_q;

   // One state machine per safety channel
   for (genvar c = 0; c < 2; c++) begin : g_chan
      active_mode_channel #(
         .P_TB_CYCLES (P_TB_CYCLES)
      ) u_chan (
         .i_clk_sys    (i_clk_sys),
         .i_reset      (i_reset),
         .i_arm        (enable_q && mode_ok),
         .i_req        (chan_req[c]),
         .i_kill       (kill),
         .i_servo_on   (i_servo_on),
         .i_release_ok (release_ok),
         .i_ctrl_tick  (i_ctrl_tick),
         .i_motor_abs  (motor_abs),
         .i_stop_level (stop_lvl_q),
         .i_decel      (chan_decel[c]),
         .i_hold_time  (hold_time_q),
         .o_active     (chan_active[c]),
         .o_speed      (chan_speed[c]),
         .o_state      (chan_state[c])
      );
   end

   // Speed override toward the loop
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         speed_cmd_q <= 32'h0;
         override_q  <= 1'b0;
      end else begin
         override_q <= any_active;
         unique case (chan_active)
            2'b01:   speed_cmd_q <= chan_speed[0];
            2'b10:   speed_cmd_q <= chan_speed[1];
            2'b11: begin
               speed_cmd_q <= (chan_speed[0] < chan_speed[1]) ?
                              chan_speed[0] : chan_speed[1];
            end
            default: speed_cmd_q <= 32'h0;
         endcase
      end
   end

   // Direction frozen at takeover so the ramp keeps its sense
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         dir_neg_q <= 1'b0;
      end else if (!any_active) begin
         dir_neg_q <= i_motor_speed[31];
      end
   end

   // Torque control cannot ramp: servo off and stop per method select
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         servo_off_q <= 1'b0;
      end else begin
         servo_off_q <= enable_q && torque_mode && !(req_a && req_b);
      end
   end

   // Position error kept while active so release can be judged
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !any_active || mode != MODE_POSITION) begin
         pos_err_q <= 40'h0;
      end else if (i_ctrl_tick) begin
         pos_err_q <= pos_err_q + {{8{i_pos_ref_delta[31]}}, i_pos_ref_delta}
                      - {{8{i_pos_fb_delta[31]}}, i_pos_fb_delta};
      end
   end

   // Status word
   always_comb begin
      status                                = 32'h0;
      status[STAT_CHAN_A_LSB +: 2]          = chan_state[0];
      status[STAT_CHAN_B_LSB +: 2]          = chan_state[1];
      status[STAT_REQ_A_BIT]                = req_a;
      status[STAT_REQ_B_BIT]                = req_b;
      status[STAT_TORQ_BIT]                 = servo_off_q;
      status[STAT_ACTIVE_BIT]               = any_active;
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rdata_d = 32'h0;
      unique case (i_reg_addr)
         REG_CTRL: begin
            rdata_d[CTRL_ENABLE_BIT]               = enable_q;
            rdata_d[CTRL_STOP_LSB +: CTRL_STOP_W]  = stop_method_q;
         end
         REG_DECEL_A:     rdata_d = decel_a_q;
         REG_DECEL_B:     rdata_d = decel_b_q;
         REG_STOP_LVL:    rdata_d = stop_lvl_q;
         REG_HOLD_TIME:   rdata_d = hold_time_q;
         REG_POS_ERR_LVL: rdata_d = pos_err_lvl_q;
         REG_SPD_REF_LVL: rdata_d = spd_ref_lvl_q;
         REG_STATUS:      rdata_d = status;
         REG_POS_ERR:     rdata_d = pos_err_q[31:0];
         REG_SPEED_CMD:   rdata_d = speed_cmd_q;
         default:         rdata_d = 32'h0;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= i_reg_rd ? rdata_d : 32'h0;
      end
   end

   assign o_reg_rdata              = rdata_q;
   assign o_decel_override         = override_q;
   assign o_decel_speed            = speed_cmd_q;
   assign o_decel_dir_neg          = dir_neg_q;
   assign o_servo_off              = servo_off_q;
   assign o_stop_method_select     = stop_method_q;
   assign o_active_stop_indication = override_q;
   assign o_pos_error              = pos_err_q;

endmodule

// ===== tb/active_mode_monitor.sv
/*
 Port checker for the active stop controller.
 Assumes one clock domain and the package constants.
*/
`timescale 1ns/1ps
module active_mode_monitor
   import active_mode_pkg::*;
(
   input wire logic        i_clk_sys,
   input wire logic        i_reset,
   input wire logic [3:0]  i_reg_addr,
   input wire logic        i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic [1:0]  i_ctrl_mode,
   input wire logic        i_servo_on,
   input wire logic        i_servo_ready,
   input wire logic        i_alarm,
   input wire logic        o_decel_override,
   input wire logic [31:0] o_decel_speed,
   input wire logic        o_servo_off,
   input wire logic        o_active_stop_indication
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);

   // Kill seen for three edges in a row: the override must be low by the third
   sequence kill_seen;
      (i_alarm || !i_servo_ready) [*3];
   endsequence
   sequence status_read;
      i_reg_rd && i_reg_addr == REG_STATUS;
   endsequence

   chk_ind_follows: assert property (
      o_active_stop_indication == o_decel_override)
      else $error("indicator differs from override");
   chk_status_bit: assert property (
      status_read |=> o_reg_rdata[STAT_ACTIVE_BIT] == o_decel_override)
      else $error("status active bit wrong");
   chk_kill_cancel: assert property (
      kill_seen |-> !o_decel_override)
      else $error("override kept after kill");
   chk_entry_healthy: assert property (
      $rose(o_decel_override) |->
         $past(i_servo_ready, 2) && !$past(i_alarm, 2))
      else $error("takeover while not ready or in alarm");
   chk_entry_mode: assert property (
      $rose(o_decel_override) |->
         $past(i_ctrl_mode, 2) inside {MODE_POSITION, MODE_SPEED})
      else $error("takeover outside position or speed mode");
   chk_servo_off_mode: assert property (
      o_servo_off |-> $past(i_ctrl_mode) == MODE_TORQUE)
      else $error("servo off outside torque mode");
   chk_ramp_down: assert property (
      $past(o_decel_override, 2) && $past(o_decel_override)
         && o_decel_override |-> o_decel_speed <= $past(o_decel_speed))
      else $error("ramp speed rose");
   chk_release_cause: assert property (
      $fell(o_decel_override) |-> !$past(i_servo_on, 2)
         || $past(i_alarm, 2) || !$past(i_servo_ready, 2))
      else $error("released while servo on");
endmodule

bind active_mode_decel_controller active_mode_monitor u_mon (
   .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
   .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
   .i_ctrl_mode(i_ctrl_mode), .i_servo_on(i_servo_on),
   .i_servo_ready(i_servo_ready), .i_alarm(i_alarm),
   .o_decel_override(o_decel_override), .o_decel_speed(o_decel_speed),
   .o_servo_off(o_servo_off),
   .o_active_stop_indication(o_active_stop_indication)
);

// ===== tb/host_ctrl_model.sv
/*
 Host motion controller model: control tick and host speed reference.
 Assumes the bench sets the wanted speed.
*/
`timescale 1ns/1ps
module host_ctrl_model #(
   parameter int P_TICK = 8
) (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   // Device status and wanted speed
   input  wire logic        i_active,
   input  wire logic [31:0] i_want_speed,
   // References to the device
   output logic             o_ctrl_tick,
   output logic [31:0]      o_host_speed_ref
);
   logic [7:0] cnt_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || o_ctrl_tick) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      o_ctrl_tick <= !i_reset && cnt_q == 8'(P_TICK - 2);
   end

   // New motion waits for release; stopping is always allowed
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_host_speed_ref <= 32'h0000_0000;
      end else if (!i_active || i_want_speed == 32'h0000_0000) begin
         o_host_speed_ref <= i_want_speed;
      end
   end
endmodule

// ===== tb/tb_top.sv
/*
 Self-checking bench for the active stop controller.
 Assumes the host model makes the control tick and speed reference.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      num_checks++; \
      if ((g) !== (e)) begin \
         fails++; \
         $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
      end \
   end
module tb_top
   import active_mode_pkg::*;
;
   logic        clk, rst, reg_wr, reg_rd, req_a, req_b;
   logic        servo_on, ready, alarm, tick, ovr, soff, ind, dneg;
   logic [3:0]  reg_addr;
   logic [1:0]  mode, meth;
   logic [31:0] wdata, rdata, motor, fb_step, want_spd, host_spd, ref_step;
   logic [31:0] spd, got, s1;
   logic [39:0] perr;
   int          fails, num_checks;
   logic [31:0] dflt [6] = '{DECEL_RST, DECEL_RST, STOP_LVL_RST,
                             HOLD_TIME_RST, POS_ERR_LVL_RST, SPD_REF_LVL_RST};
   logic [3:0]  c_adr [3] = '{REG_DECEL_A, REG_DECEL_B, REG_HOLD_TIME};
   logic [31:0] c_in [3] = '{32'h0, 32'h0000_9C40, 32'h0000_FFFF};
   logic [31:0] c_out [3] = '{32'h1, 32'h0000_7530, 32'h0000_2710};

   always #10 clk = ~clk;

   active_mode_decel_controller #(.P_TB_CYCLES(10)) dut (
      .i_clk_sys(clk), .i_reset(rst), .i_reg_addr(reg_addr),
      .i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .o_reg_rdata(rdata), .i_safety_req_a(req_a), .i_safety_req_b(req_b),
      .i_ctrl_mode(mode), .i_servo_on(servo_on), .i_servo_ready(ready),
      .i_alarm(alarm), .i_ctrl_tick(tick), .i_host_speed_ref(host_spd),
      .i_motor_speed(motor), .i_pos_ref_delta(ref_step),
      .i_pos_fb_delta(fb_step), .o_decel_override(ovr),
      .o_decel_speed(spd), .o_decel_dir_neg(dneg), .o_servo_off(soff),
      .o_stop_method_select(meth), .o_active_stop_indication(ind),
      .o_pos_error(perr));

   host_ctrl_model #(.P_TICK(8)) host (
      .i_clk_sys(clk), .i_reset(rst), .i_active(ind),
      .i_want_speed(want_spd), .o_ctrl_tick(tick),
      .o_host_speed_ref(host_spd));

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      wdata    <= d;
      reg_wr   <= 1'b1;
      @(posedge clk);
      reg_wr   <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 got = rdata;
   endtask

   task automatic see(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   initial begin
      repeat (6000) @(posedge clk);
      fails++;
      close_out();
   end

   initial begin
      {clk, reg_wr, reg_rd, alarm, fails, num_checks} = '0;
      {rst, req_a, req_b, servo_on, ready} = 5'h1F;
      reg_addr = 4'h0;
      wdata    = 32'h0;
      mode     = MODE_POSITION;
      motor    = 32'h0000_03E8;
      fb_step  = 32'h0;
      ref_step = 32'h0;
      want_spd = 32'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (dflt[i]) begin
         rd(4'(i + 1));
         `CHK("default", dflt[i], got)
      end
      rd(4'hA);
      `CHK("unmapped", 32'h0, got)
      foreach (c_adr[i]) begin
         wr(c_adr[i], c_in[i]);
         rd(c_adr[i]);
         `CHK("clamp", c_out[i], got)
      end
      wr(REG_DECEL_A, 32'h0000_7530);
      wr(REG_DECEL_B, 32'h0000_0001);
      wr(REG_HOLD_TIME, 32'h0000_0002);
      req_a <= 1'b0;
      see(10);
      `CHK("disabled", 1'b0, ovr)
      // Request high first; the synchroniser lags two edges behind the pin
      req_a <= 1'b1;
      see(3);
      wr(REG_CTRL, 32'h1);
      see(4);
      // Two channels, different ramps, then stop, hold and release
      @(posedge clk);
      req_a   <= 1'b0;
      fb_step <= 32'h0000_0005;
      see(4);
      `CHK("take_a", 1'b1, ovr)
      `CHK("indicator", 1'b1, ind)
      `CHK("take_spd", 1'b1, spd > 32'h0000_03DE)
      see(40);
      @(posedge clk);
      req_b <= 1'b0;
      see(4);
      rd(REG_STATUS);
      `CHK("both_decel", 4'h5, got[3:0])
      `CHK("status_act", 1'b1, got[STAT_ACTIVE_BIT])
      `CHK("min_speed", 1'b1, spd < 32'h0000_03E8)
      `CHK("perr_sign", 1'b1, perr[39])
      s1 = spd;
      see(16);
      `CHK("ramp_falls", 1'b1, spd < s1)
      @(posedge clk);
      motor   <= 32'h0000_000A;
      fb_step <= 32'h0;
      see(3);
      rd(REG_STATUS);
      `CHK("both_hold", 4'hF, got[3:0])
      @(posedge clk);
      req_a <= 1'b1;
      req_b <= 1'b1;
      see(4);
      rd(REG_STATUS);
      `CHK("hold_keeps", 4'hF, got[3:0])
      see(20);
      rd(REG_STATUS);
      `CHK("wait_servo", 4'hA, got[3:0])
      `CHK("still_on", 1'b1, ovr)
      @(posedge clk);
      servo_on <= 1'b0;
      see(3);
      `CHK("released", 1'b0, ovr)
      `CHK("perr_clear", 40'h0, perr)
      // Speed mode: host reference above level blocks release
      wr(REG_HOLD_TIME, 32'h0);
      mode     <= MODE_SPEED;
      want_spd <= 32'h0000_01F4;
      motor    <= 32'hFFFF_FC18;
      see(4);
      @(posedge clk);
      req_a <= 1'b0;
      see(4);
      `CHK("spd_take", 1'b1, ovr)
      `CHK("dir_neg", 1'b1, dneg)
      @(posedge clk);
      motor <= 32'h0000_000A;
      req_a <= 1'b1;
      see(30);
      `CHK("ref_holds", 1'b1, ovr)
      @(posedge clk);
      want_spd <= 32'h0;
      see(5);
      `CHK("ref_drop", 1'b0, ovr)
      // Position error above level blocks release; alarm cancels
      @(posedge clk);
      mode    <= MODE_POSITION;
      motor   <= 32'h0000_03E8;
      req_a    <= 1'b0;
      ref_step <= 32'h0000_0100;
      see(16);
      @(posedge clk);
      motor    <= 32'h0000_000A;
      ref_step <= 32'h0;
      req_a    <= 1'b1;
      see(30);
      `CHK("perr_holds", 1'b1, ovr)
      `CHK("dir_pos", 1'b0, dneg)
      @(posedge clk);
      alarm <= 1'b1;
      see(3);
      `CHK("alarm_cancel", 1'b0, ovr)
      @(posedge clk);
      alarm <= 1'b0;
      mode  <= MODE_TORQUE;
      req_a <= 1'b0;
      for (int m = 0; m < 4; m++) begin
         wr(REG_CTRL, 32'(m * 2 + 1));
         see(4);
         `CHK("servo_off", 1'b1, soff)
         `CHK("method", 2'(m), meth)
         `CHK("no_take", 1'b0, ovr)
      end
      close_out();
   end
endmodule
